// ### include/reset_ctl_map.vh
// constants for the reset and protection controller: register offsets,
// field positions, reset values, guard patterns and timing counts.
// assumes a 250 MHz clock and a 32-bit register bus.
`ifndef RESET_CTL_MAP_VH
`define RESET_CTL_MAP_VH
// ==================================================================
// register offsets (byte addresses)
`define OFF_CTRL 4'h0
`define OFF_STATUS 4'h4
`define OFF_CAUSE 4'h8
// ==================================================================
// control fields
`define CTRL_IRQ_LVL_LO 0
`define CTRL_IRQ_EN 2
`define CTRL_RST_LVL_LO 4
`define CTRL_RST_EN 6
`define CTRL_PIN_SAMPLE_OFF 8
`define CTRL_CLK_EXT 12
`define CTRL_RESET 32'h0000_0000
`define CTRL_MASK 32'h0000_1177
// ==================================================================
// cause bits: pin, watchdog, power-on, supply drop
`define CAUSE_PIN 0
`define CAUSE_WDT 1
`define CAUSE_POR 2
`define CAUSE_DROP 3
// ==================================================================
// guard word patterns kept in the dedicated flash location
`define GUARD_PAT_ONE 32'h1234_5678
`define GUARD_PAT_TWO 32'h8765_4321
`define GUARD_PAT_THREE 32'h4321_8765
`define GUARD_PAT_NOSAMPLE 32'h4E69_7370
// ==================================================================
// timing
`define CLK_PERIOD_NS 4
`define PIN_MIN_LOW_NS 50
`define PIN_MIN_LOW_CYC ((`PIN_MIN_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OSC_SETTLE_CYC 16
`define FLASH_INIT_CYC 8
`define BOOT_ADDR 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### rtl/settle_timer.v
// counts a fixed number of cycles while its start level is held.
// assumes start drops to restart the count.
`timescale 1ns/1ps
module settle_timer #(
  parameter WIDTH = 8,
  parameter [WIDTH-1:0] COUNT = 8'h10
) (
  input wire clock,
  input wire sys_rst,
  input wire start,
  output reg done_ff
);
  reg [WIDTH-1:0] count_ff;
  // ================================================================
  // counter, cleared whenever start falls
  always @(posedge clock) begin
    if (sys_rst || !start) begin
      count_ff <= {WIDTH{1'b0}};
      done_ff <= 1'b0;
    end else if (count_ff == COUNT - 1'b1) begin
      done_ff <= 1'b1; // sticks until start drops
    end else begin
      count_ff <= count_ff + 1'b1;
    end
  end
endmodule // settle_timer

// ### rtl/level_pick.v
// picks one of four supply-below comparator outputs by a 2-bit level.
// assumes comparator outputs are synchronous to the clock.
`timescale 1ns/1ps
module level_pick (
  input wire clock,
  input wire sys_rst,
  input wire [3:0] below,
  input wire [1:0] sel,
  input wire enable,
  output reg hit_ff
);
  // ================================================================
  // registered selection, gated by enable
  always @(posedge clock) begin
    if (sys_rst) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= enable & below[sel];
    end
  end
endmodule // level_pick

// ### rtl/reset_and_protection_control.v
// reset merge, boot sequencing, supply drop handling, flash read guard
// and test-port selection, with an AXI4-Lite register slave.
// assumes all inputs synchronous to clock; sys_rst comes from a
// power-on cell and outlives chip reset so cause bits survive.
`timescale 1ns/1ps
`include "reset_ctl_map.vh"
module reset_and_protection_control (
  input wire clock,
  input wire sys_rst,
  // reset sources
  input wire resetPinN,
  input wire wdtReset,
  input wire porReset,
  input wire supplyUsable,
  input wire [3:0] supplyBelow,
  // flash controller
  input wire flashReady,
  input wire [31:0] guardWord,
  input wire extClkStable,
  // outputs to the chip
  output reg chipResetN_ff,
  output reg oscStart_ff,
  output reg flashInit_ff,
  output reg guardRead_ff,
  output reg [31:0] bootAddr_ff,
  output reg clkSelExt_ff,
  output reg dropIrq_ff,
  output reg swdEnable_ff,
  output reg bscanEnable_ff,
  output reg jtagDebug_ff,
  output reg [1:0] ispMode_ff,
  output reg ispSector0Lock_ff,
  output reg ispPinSample_ff,
  output reg iapEnable_ff,
  // AXI4-Lite slave
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam [2:0] ST_HOLD = 3'h0;
  localparam [2:0] ST_OSC = 3'h1;
  localparam [2:0] ST_FLASH = 3'h2;
  localparam [2:0] ST_GUARD = 3'h3;
  localparam [2:0] ST_RUN = 3'h4;
  localparam integer PIN_CYC_FULL = `PIN_MIN_LOW_CYC;
  localparam [7:0] PIN_CYC = PIN_CYC_FULL[7:0];

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [31:0] ctrl_ff;
  reg [3:0] cause_ff;
  reg [1:0] guardLvl_ff;
  reg pinSampleOff_ff;
  reg [7:0] pinLow_ff;
  reg [3:0] awAddr_ff;
  reg [31:0] wData_ff;
  reg [3:0] wStrb_ff;
  reg haveAw_ff;
  reg haveW_ff;
  wire dropBelow;
  wire dropReset;
  wire oscDone;
  wire flashDone;
  wire anySource;
  wire pinHold;
  wire doWrite;
  wire [31:0] mergedCtrl;
  wire [3:0] causeHit;
  wire [3:0] causeClr;

  // ================================================================
  // supply drop detection: one picker for the interrupt, one for reset
  level_pick u_irqPick (
    .clock(clock),
    .sys_rst(sys_rst),
    .below(supplyBelow),
    .sel(ctrl_ff[`CTRL_IRQ_LVL_LO+1:`CTRL_IRQ_LVL_LO]),
    .enable(1'b1),
    .hit_ff(dropBelow)
  );
  level_pick u_rstPick (
    .clock(clock),
    .sys_rst(sys_rst),
    .below(supplyBelow),
    .sel(ctrl_ff[`CTRL_RST_LVL_LO+1:`CTRL_RST_LVL_LO]),
    .enable(ctrl_ff[`CTRL_RST_EN]),
    .hit_ff(dropReset)
  );

  // ================================================================
  // reset merge; a pin low is stretched so a short pulse is never lost
  always @(posedge clock) begin
    if (sys_rst) begin
      pinLow_ff <= 8'h00;
    end else if (!resetPinN) begin
      pinLow_ff <= PIN_CYC;
    end else if (pinLow_ff != 8'h00) begin
      pinLow_ff <= pinLow_ff - 8'h01;
    end
  end
  assign pinHold = !resetPinN || (pinLow_ff != 8'h00);
  assign anySource = pinHold | wdtReset | porReset | dropReset;

  // ================================================================
  // settle timers for oscillator start and flash init
  settle_timer #(.WIDTH(8), .COUNT(`OSC_SETTLE_CYC)) u_oscTimer (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(oscStart_ff),
    .done_ff(oscDone)
  );
  settle_timer #(.WIDTH(8), .COUNT(`FLASH_INIT_CYC)) u_flashTimer (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(flashInit_ff),
    .done_ff(flashDone)
  );

  // ================================================================
  // boot sequencer; any source sends it back to hold at once
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_HOLD: begin
        if (supplyUsable) begin
          nxt_state = ST_OSC;
        end
      end
      ST_OSC: begin
        if (oscDone) begin
          nxt_state = ST_FLASH;
        end
      end
      ST_FLASH: begin
        if (flashDone && flashReady) begin
          nxt_state = ST_GUARD;
        end
      end
      ST_GUARD: begin
        nxt_state = ST_RUN;
      end
      ST_RUN: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_HOLD;
      end
    endcase
    if (anySource || !supplyUsable) begin
      nxt_state = ST_HOLD;
    end
  end

  // flash and guard requests follow the state, the oscillator request holds once set; release is last
  always @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= ST_HOLD;
      oscStart_ff <= 1'b0;
      flashInit_ff <= 1'b0;
      guardRead_ff <= 1'b0;
      chipResetN_ff <= 1'b0;
      bootAddr_ff <= `BOOT_ADDR;
    end else begin
      state_ff <= nxt_state;
      // oscillator keeps running once started while the supply is usable, even across a new reset
      oscStart_ff <= oscStart_ff ? supplyUsable : (nxt_state == ST_OSC);
      flashInit_ff <= (nxt_state == ST_FLASH);
      guardRead_ff <= (nxt_state == ST_GUARD);
      chipResetN_ff <= (nxt_state == ST_RUN);
      bootAddr_ff <= `BOOT_ADDR;
    end
  end

  // ================================================================
  // guard level is latched from the flash word only during boot
  always @(posedge clock) begin
    if (sys_rst) begin
      guardLvl_ff <= 2'h0;
      pinSampleOff_ff <= 1'b0;
    end else if (state_ff == ST_GUARD) begin
      pinSampleOff_ff <= (guardWord == `GUARD_PAT_NOSAMPLE);
      if (guardWord == `GUARD_PAT_ONE) begin
        guardLvl_ff <= 2'h1;
      end else if (guardWord == `GUARD_PAT_TWO) begin
        guardLvl_ff <= 2'h2;
      end else if (guardWord == `GUARD_PAT_THREE) begin
        guardLvl_ff <= 2'h3;
      end else begin
        guardLvl_ff <= 2'h0; // any other word leaves the part open
      end
    end
  end

  // ================================================================
  // access gating and test-port selection
  always @(posedge clock) begin
    if (sys_rst) begin
      swdEnable_ff <= 1'b0;
      bscanEnable_ff <= 1'b0;
      jtagDebug_ff <= 1'b0;
      ispMode_ff <= 2'h0;
      ispSector0Lock_ff <= 1'b0;
      ispPinSample_ff <= 1'b0;
      iapEnable_ff <= 1'b0;
    end else begin
      // pin level picks the port; wire debug needs the part out of reset
      bscanEnable_ff <= !resetPinN;
      swdEnable_ff <= resetPinN && chipResetN_ff && (guardLvl_ff == 2'h0);
      jtagDebug_ff <= 1'b0;
      ispMode_ff <= guardLvl_ff;
      ispSector0Lock_ff <= (guardLvl_ff == 2'h1);
      ispPinSample_ff <= (guardLvl_ff != 2'h3) && !pinSampleOff_ff
        && !ctrl_ff[`CTRL_PIN_SAMPLE_OFF];
      iapEnable_ff <= 1'b1;
    end
  end

  // ================================================================
  // interrupt request and clock selection
  always @(posedge clock) begin
    if (sys_rst) begin
      dropIrq_ff <= 1'b0;
      clkSelExt_ff <= 1'b0;
    end else begin
      dropIrq_ff <= dropBelow && ctrl_ff[`CTRL_IRQ_EN];
      // fast oscillator is selected while chip reset is held; the control bit survives it
      if (!chipResetN_ff) begin
        clkSelExt_ff <= 1'b0;
      end else begin
        // software must have waited for stability; refuse otherwise
        clkSelExt_ff <= ctrl_ff[`CTRL_CLK_EXT] && extClkStable;
      end
    end
  end

  // ================================================================
  // AXI4-Lite write path: address and data taken in either order
  assign doWrite = haveAw_ff && haveW_ff && !s_axi_bvalid;
  assign mergedCtrl = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}},
    {8{wStrb_ff[0]}}} & wData_ff | ~{{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}},
    {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}} & ctrl_ff;
  always @(posedge clock) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      haveAw_ff <= 1'b0;
      haveW_ff <= 1'b0;
      awAddr_ff <= 4'h0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
    end else begin
      s_axi_awready <= !haveAw_ff && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !haveW_ff && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        haveAw_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        haveW_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
      end
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_ff == `OFF_CTRL || awAddr_ff == `OFF_CAUSE) ?
          `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        haveAw_ff <= 1'b0;
        haveW_ff <= 1'b0;
      end
    end
  end

  // control register
  always @(posedge clock) begin
    if (sys_rst) begin
      ctrl_ff <= `CTRL_RESET;
    end else if (doWrite && awAddr_ff == `OFF_CTRL) begin
      ctrl_ff <= mergedCtrl & `CTRL_MASK;
    end
  end

  // cause flags: a new event wins over a write-one clear
  assign causeHit = {dropReset, porReset, wdtReset, pinHold};
  assign causeClr = (doWrite && awAddr_ff == `OFF_CAUSE && wStrb_ff[0]) ?
    wData_ff[3:0] : 4'h0;
  always @(posedge clock) begin
    if (sys_rst) begin
      cause_ff <= 4'h0;
    end else begin
      cause_ff <= (cause_ff & ~causeClr) | causeHit;
    end
  end

  // ================================================================
  // AXI4-Lite read path; data registered one cycle after the address
  always @(posedge clock) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          `OFF_CTRL: begin
            s_axi_rdata <= ctrl_ff;
          end
          `OFF_STATUS: begin
            s_axi_rdata <= {20'h00000, 1'b0, state_ff, 2'h0, guardLvl_ff,
              1'b0, clkSelExt_ff, chipResetN_ff, dropBelow};
          end
          `OFF_CAUSE: begin
            s_axi_rdata <= {28'h0000000, cause_ff};
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // reset_and_protection_control

// ### verif/reset_and_protection_control_asserts.sv
// checker for the reset and protection controller, bound to its top.
// assumes all signals sampled on the rising edge of one clock.
`timescale 1ns/1ps
module reset_and_protection_control_asserts (
  input wire clock,
  input wire sys_rst,
  input wire resetPinN,
  input wire wdtReset,
  input wire porReset,
  input wire chipResetN_ff,
  input wire oscStart_ff,
  input wire flashInit_ff,
  input wire [31:0] bootAddr_ff,
  input wire clkSelExt_ff,
  input wire swdEnable_ff,
  input wire bscanEnable_ff,
  input wire jtagDebug_ff,
  input wire [1:0] ispMode_ff,
  input wire ispSector0Lock_ff,
  input wire ispPinSample_ff,
  input wire iapEnable_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // boot steps
  sequence s_boot;
    $rose(chipResetN_ff);
  endsequence
  sequence s_flash_seen;
    $past(flashInit_ff) || $past(flashInit_ff, 2) || $past(flashInit_ff, 3);
  endsequence
  // ==========================================
  // reset and release
  source_holds_reset_a: assert property (
    (wdtReset || porReset || !resetPinN) |-> ##[1:2] !chipResetN_ff)
    else $error("reset source did not hold chip reset");
  pin_stretch_a: assert property (
    $rose(resetPinN) |-> !chipResetN_ff [*8])
    else $error("short pin pulse released too soon");
  release_after_flash_a: assert property (
    s_boot |-> s_flash_seen) else $error("release without flash init");
  osc_on_release_a: assert property (
    s_boot |-> oscStart_ff && iapEnable_ff) else $error("osc or iap off at release");
  boot_addr_zero_a: assert property (
    bootAddr_ff == 32'h0000_0000) else $error("boot address not zero");
  fast_clk_reset_a: assert property (
    !chipResetN_ff [*2] |-> !clkSelExt_ff) else $error("other clock kept in reset");
  // ==========================================
  // debug and guard
  swd_off_reset_a: assert property (
    $past(!chipResetN_ff) |-> !swdEnable_ff) else $error("wire debug on in reset");
  bscan_follows_pin_a: assert property (
    !$past(sys_rst) |-> bscanEnable_ff == !$past(resetPinN))
    else $error("scan select not following pin");
  jtag_no_debug_a: assert property (
    !jtagDebug_ff) else $error("scan port gave debug access");
  guard_one_lock_a: assert property (
    ispMode_ff == 2'h1 |-> ispSector0Lock_ff) else $error("sector 0 unlocked");
  swd_guard_zero_a: assert property (
    swdEnable_ff |-> ispMode_ff == 2'h0) else $error("wire debug with guard set");
  guard_three_shut_a: assert property (
    ispMode_ff == 2'h3 |-> !ispPinSample_ff && !swdEnable_ff)
    else $error("level three left an entry open");
endmodule // reset_and_protection_control_asserts
bind reset_and_protection_control reset_and_protection_control_asserts u_chk (
  .clock, .sys_rst, .resetPinN, .wdtReset, .porReset, .chipResetN_ff, .oscStart_ff,
  .flashInit_ff, .bootAddr_ff, .clkSelExt_ff, .swdEnable_ff, .bscanEnable_ff,
  .jtagDebug_ff, .ispMode_ff, .ispSector0Lock_ff, .ispPinSample_ff, .iapEnable_ff);

// ### verif/flash_guard_model.sv
// flash controller stand-in: ready after a latency, serves the guard word.
// assumes init request and guard read pulse come from the controller.
`timescale 1ns/1ps
module flash_guard_model (
  input wire clock,
  input wire flashInit,
  input wire guardRead,
  input wire [31:0] pattern,
  input wire [7:0] latency,
  output reg flashReady = 1'b0,
  output wire [31:0] guardWord
);
  reg [7:0] waitCnt = 8'h00;
  reg wordValid = 1'b0;
  reg readSeen = 1'b0;
  // ready only after latency, dropped with the request
  always @(posedge clock) begin
    if (!flashInit) begin
      waitCnt <= 8'h00;
      flashReady <= 1'b0;
    end else if (waitCnt >= latency) begin
      flashReady <= 1'b1;
    end else begin
      waitCnt <= waitCnt + 8'h01;
    end
  end
  // word valid from ready to the read; outside it the bus shows garbage
  always @(posedge clock) begin
    readSeen <= guardRead;
    if (readSeen) begin
      wordValid <= 1'b0;
    end else if (flashReady && flashInit) begin
      wordValid <= 1'b1;
    end
  end
  assign guardWord = wordValid ? pattern : ~pattern;
endmodule // flash_guard_model

// ### verif/tb_reset_and_protection_control.sv
// self-checking bench: reset sources, guard levels, drop detect, clock pick.
// assumes the flash model above and the bound checker.
`timescale 1ns/1ps
`include "reset_ctl_map.vh"
module tb_reset_and_protection_control;
  reg clock = 1'b0;
  reg sys_rst = 1'b1;
  reg resetPinN = 1'b1;
  reg wdtReset = 1'b0;
  reg porReset = 1'b1;
  reg supplyUsable = 1'b1;
  reg [3:0] s_axi_wstrb = 4'hF;
  reg [3:0] supplyBelow = 4'h0;
  reg extClkStable = 1'b0;
  reg [31:0] pattern = 32'h0000_0000;
  reg [7:0] latency = 8'h00;
  reg [3:0] s_axi_awaddr = 4'h0;
  reg [3:0] s_axi_araddr = 4'h0;
  reg [31:0] s_axi_wdata = 32'h0000_0000;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  wire chipResetN_ff, oscStart_ff, flashInit_ff, guardRead_ff, clkSelExt_ff, dropIrq_ff;
  wire swdEnable_ff, bscanEnable_ff, jtagDebug_ff, ispSector0Lock_ff, ispPinSample_ff;
  wire iapEnable_ff, flashReady, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire s_axi_arready, s_axi_rvalid;
  wire [1:0] ispMode_ff, s_axi_bresp, s_axi_rresp;
  wire [31:0] bootAddr_ff, guardWord, s_axi_rdata;
  integer bad_count = 0, total_checks = 0, seed = 37, i, l, n;
  reg [31:0] rdat, pat;
  reg [1:0] resp, lvl;
  // ==========================================
  // design and partner
  reset_and_protection_control dut (.clock, .sys_rst, .resetPinN, .wdtReset, .porReset,
    .supplyUsable, .supplyBelow, .flashReady, .guardWord, .extClkStable,
    .chipResetN_ff, .oscStart_ff, .flashInit_ff, .guardRead_ff, .bootAddr_ff,
    .clkSelExt_ff, .dropIrq_ff, .swdEnable_ff, .bscanEnable_ff, .jtagDebug_ff,
    .ispMode_ff, .ispSector0Lock_ff, .ispPinSample_ff, .iapEnable_ff, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  flash_guard_model partner (.clock, .flashInit(flashInit_ff), .guardRead(guardRead_ff),
    .pattern, .latency, .flashReady, .guardWord);
  // ==========================================
  // helpers
  initial begin
    forever #2 clock = ~clock;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // each channel dropped at the edge its ready is seen
  // no local limit: only the watchdog ends a hung transfer
  task axi_wr(input [3:0] a, input [31:0] d, output [1:0] r);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge clock);
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge clock);
    end
  endtask
  task axi_rd(input [3:0] a, output [31:0] d, output [1:0] r);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge clock);
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clock);
    end
  endtask
  // bounded wait for release, then let the one-cycle-late outputs land
  task wait_run;
    begin
      n = 0;
      while (chipResetN_ff !== 1'b1 && n < 400) begin
        @(posedge clock);
        n = n + 1;
      end
      chk(n < 400, 1);
      repeat (2) @(posedge clock);
    end
  endtask
  task wdt_boot(input [31:0] p);
    begin
      pattern <= p;
      latency <= $random(seed) & 8'h0F;
      wdtReset <= 1'b1;
      repeat (3) @(posedge clock);
      wdtReset <= 1'b0;
      wait_run;
      // oscillator keeps running across this reset, so only flash init is timed
      chk(n > `FLASH_INIT_CYC, 1);
    end
  endtask
  // reference model of the guard word decode
  function [1:0] level_of(input [31:0] w);
    level_of = (w == `GUARD_PAT_ONE) ? 2'h1 : (w == `GUARD_PAT_TWO) ? 2'h2 :
      (w == `GUARD_PAT_THREE) ? 2'h3 : 2'h0;
  endfunction
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    bad_count = bad_count + 1;
    print_verdict;
  end
  // ==========================================
  // tests
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    porReset <= 1'b0;
    wait_run;
    chk(bootAddr_ff, `BOOT_ADDR);
    chk({oscStart_ff, clkSelExt_ff}, 2'h2);
    axi_rd(`OFF_CAUSE, rdat, resp);
    chk(rdat[`CAUSE_POR], 1);
    axi_rd(`OFF_CTRL, rdat, resp);
    chk(rdat, `CTRL_RESET);
    $display("power on done");
    for (i = 0; i < 5; i = i + 1) begin
      pat = (i == 0) ? `GUARD_PAT_ONE : (i == 1) ? `GUARD_PAT_TWO :
        (i == 2) ? `GUARD_PAT_THREE : (i == 3) ? `GUARD_PAT_NOSAMPLE : $random(seed);
      lvl = level_of(pat);
      wdt_boot(pat);
      chk(ispMode_ff, lvl);
      chk(swdEnable_ff, lvl == 2'h0);
      chk(ispPinSample_ff, !(lvl == 2'h3 || pat == `GUARD_PAT_NOSAMPLE));
      chk(iapEnable_ff, 1);
      if (lvl == 2'h1) chk(ispSector0Lock_ff, 1);
      axi_rd(`OFF_STATUS, rdat, resp);
      chk(rdat[5:4], lvl);
    end
    $display("guard levels done");
    axi_wr(`OFF_CTRL, 32'h1 << `CTRL_PIN_SAMPLE_OFF, resp);
    chk({ispPinSample_ff, ispMode_ff, swdEnable_ff}, 4'h1);
    axi_wr(`OFF_CAUSE, 32'h0000_000F, resp);
    axi_rd(`OFF_CAUSE, rdat, resp);
    chk(rdat, 0);
    resetPinN <= 1'b0;
    repeat (`PIN_MIN_LOW_CYC) @(posedge clock);
    chk({bscanEnable_ff, swdEnable_ff, chipResetN_ff}, 3'h4);
    resetPinN <= 1'b1;
    wait_run;
    chk({bscanEnable_ff, swdEnable_ff}, 2'h1);
    axi_rd(`OFF_CAUSE, rdat, resp);
    chk(rdat[3:0], 4'h1 << `CAUSE_PIN);
    $display("pin reset done");
    for (l = 0; l < 4; l = l + 1) begin
      axi_wr(`OFF_CTRL, (1 << `CTRL_IRQ_EN) | l, resp);
      supplyBelow <= 4'hF ^ (4'h1 << l);
      repeat (3) @(posedge clock);
      chk(dropIrq_ff, 0);
      supplyBelow <= 4'h1 << l;
      repeat (3) @(posedge clock);
      chk(dropIrq_ff, 1);
      axi_wr(`OFF_CTRL, l, resp);
      chk(dropIrq_ff, 0);
      axi_rd(`OFF_STATUS, rdat, resp);
      chk(rdat[0], 1);
      axi_wr(`OFF_CTRL, (1 << `CTRL_RST_EN) | (l << `CTRL_RST_LVL_LO), resp);
      @(posedge clock); // picker adds one edge before reset lands
      chk(chipResetN_ff, 0);
      supplyBelow <= 4'h0;
      wait_run;
      axi_rd(`OFF_CAUSE, rdat, resp);
      chk(rdat[`CAUSE_DROP], 1);
      axi_wr(`OFF_CAUSE, 32'h0000_000F, resp);
    end
    $display("supply drop done");
    axi_wr(`OFF_CTRL, 32'h1 << `CTRL_CLK_EXT, resp);
    chk(clkSelExt_ff, 0);
    extClkStable <= 1'b1;
    repeat (3) @(posedge clock);
    axi_rd(`OFF_STATUS, rdat, resp);
    chk({clkSelExt_ff, rdat[2]}, 2'h3);
    axi_rd(4'hC, rdat, resp);
    chk(resp, `RESP_SLVERR);
    chk(rdat, 0);
    axi_wr(`OFF_STATUS, 32'h0, resp);
    chk(resp, `RESP_SLVERR);
    $display("clock and bus done");
    // supply loss stops the oscillator, so the next boot waits for it again
    supplyUsable <= 1'b0;
    repeat (3) @(posedge clock);
    chk({chipResetN_ff, oscStart_ff, clkSelExt_ff}, 3'h0);
    supplyUsable <= 1'b1;
    wait_run;
    chk(n > `OSC_SETTLE_CYC + `FLASH_INIT_CYC, 1);
    // byte strobe: only byte 0 of the control word may change
    s_axi_wstrb <= 4'h1;
    axi_wr(`OFF_CTRL, 32'hFFFF_FFFF, resp);
    s_axi_wstrb <= 4'hF;
    axi_rd(`OFF_CTRL, rdat, resp);
    chk(rdat, (`CTRL_MASK & 32'h0000_00FF) | (32'h1 << `CTRL_CLK_EXT));
    $display("supply loss and strobe done");
    print_verdict;
  end
endmodule // tb_reset_and_protection_control
